// ---- hw/apr_pkg.sv ----
// Register offsets, field layouts and reset values for the AVB register bank.
package apr_pkg;

  localparam int unsigned ADDR_W = 17;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [16:0] RX_BUF_CTRL_OFS  = 17'h12004;
  localparam logic [16:0] SEND_SLOPE_OFS   = 17'h1200c;
  localparam logic [16:0] IDLE_SLOPE_OFS   = 17'h12010;
  localparam logic [16:0] NS_OFFSET_OFS    = 17'h12800;
  localparam logic [16:0] SEC_LO_OFS       = 17'h12808;
  localparam logic [16:0] SEC_HI_OFS       = 17'h1280c;
  localparam logic [16:0] INCR_OFS         = 17'h12810;
  localparam logic [16:0] NOW_NS_OFS       = 17'h12814;
  localparam logic [16:0] NOW_SEC_LO_OFS   = 17'h12818;
  localparam logic [16:0] NOW_SEC_HI_OFS   = 17'h1281c;
  localparam logic [16:0] RTC_IRQ_CLR_OFS  = 17'h12820;
  localparam logic [16:0] PHASE_ADJ_OFS    = 17'h12824;

  // ----------------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------------
  localparam int unsigned RX_FLUSH_BIT  = 0;
  localparam int unsigned RX_BIN_LSB    = 8;
  localparam int unsigned RX_BIN_W      = 4;
  localparam int unsigned SLOPE_W       = 20;
  localparam int unsigned NS_W          = 30;
  localparam int unsigned SEC_LO_W      = 32;
  localparam int unsigned SEC_HI_W      = 16;
  localparam int unsigned INCR_W        = 26;
  localparam int unsigned FRAC_W        = 20;
  localparam int unsigned RTC_IRQ_BIT   = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [19:0] SEND_SLOPE_RST = 20'h00800;
  localparam logic [19:0] IDLE_SLOPE_RST = 20'h01800;
  localparam logic [29:0] NS_OFFSET_RST  = 30'h00000000;
  localparam logic [31:0] SEC_LO_RST     = 32'h00000000;
  localparam logic [15:0] SEC_HI_RST     = 16'h0000;
  localparam logic [3:0]  RX_BIN_RST     = 4'h0;
  localparam logic [25:0] INCR_RST       = 26'h0000000;
  localparam logic [29:0] PHASE_RST      = 30'h00000000;

endpackage : apr_pkg

// ---- hw/apr_regs.sv ----
// AVB register bank: RX timing buffer control, shaper slopes, RTC registers.
`timescale 1ns/1ps

module apr_regs #(
  parameter bit          AVB_PRESENT = 1'b1,
  parameter int unsigned NS_PER_SEC  = 1000000000
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [16:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        rx_ts_stored,
  input  wire logic [3:0]  rx_ts_bin,
  input  wire logic [3:0]  rx_rd_ptr,
  output logic             rx_flush,
  output logic      [3:0]  rx_wr_ptr_load,
  output logic             rx_irq,
  output logic      [19:0] send_slope,
  output logic      [19:0] idle_slope,
  output logic             rtc_load,
  output logic      [29:0] rtc_ns,
  output logic      [47:0] rtc_sec,
  output logic      [29:0] phase_adjust,
  output logic             rtc_irq_clear
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic        flush;
    logic [3:0]  wr_ptr_load;
    logic        irq;
    logic [3:0]  bin;
    logic [19:0] send_slope;
    logic [19:0] idle_slope;
    logic [29:0] ns_ofs;
    logic [31:0] sec_lo_ofs;
    logic [15:0] sec_hi_ofs;
    logic [25:0] incr;
    logic [29:0] phase;
    logic        load;
    logic        irq_clr;
    logic [29:0] ns;
    logic [19:0] frac;
    logic [47:0] sec;
    logic [47:0] snap_sec;
  } apr_state_t;

  localparam logic [29:0] NS_LIMIT = 30'(NS_PER_SEC);

  apr_state_t st_r;
  apr_state_t st_nxt;

  logic        ctrl_hit;
  logic [26:0] frac_sum;
  logic [30:0] ns_sum;

  always_comb begin
    st_nxt   = st_r;
    ctrl_hit = (reg_addr == apr_pkg::RX_BUF_CTRL_OFS) && (reg_wr || reg_rd);
    st_nxt.flush   = 1'b0;
    st_nxt.load    = 1'b0;
    st_nxt.irq_clr = 1'b0;
    st_nxt.rdata   = 32'h00000000;

    // --------------------------------------------------------------------
    // RX buffer control
    // --------------------------------------------------------------------
    // RX bin index follows completed timestamp writes.
    if (rx_ts_stored) begin
      st_nxt.bin = rx_ts_bin;
    end
    // A new reception wins over a clear in the same cycle.
    if (rx_ts_stored) begin
      st_nxt.irq = 1'b1;
    end else if (ctrl_hit) begin
      st_nxt.irq = 1'b0;
    end

    // --------------------------------------------------------------------
    // RTC counter
    // --------------------------------------------------------------------
    // The carry out of the fraction can reach 64 ns, so all seven bits
    // above the fraction feed the nanosecond sum.
    frac_sum = {7'h00, st_r.frac} + {1'b0, st_r.incr};
    ns_sum   = {1'b0, st_r.ns} + {24'h000000, frac_sum[26:20]};
    st_nxt.frac = frac_sum[19:0];
    if (ns_sum >= {1'b0, NS_LIMIT}) begin
      st_nxt.ns  = 30'(ns_sum - {1'b0, NS_LIMIT});
      st_nxt.sec = st_r.sec + 48'h000000000001;
    end else begin
      st_nxt.ns = ns_sum[29:0];
    end

    // --------------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------------
    if (AVB_PRESENT && reg_wr) begin
      unique case (reg_addr)
        apr_pkg::RX_BUF_CTRL_OFS: begin
          if (reg_wdata[apr_pkg::RX_FLUSH_BIT]) begin
            st_nxt.flush       = 1'b1;
            st_nxt.wr_ptr_load = rx_rd_ptr;
          end
        end
        apr_pkg::SEND_SLOPE_OFS: st_nxt.send_slope = reg_wdata[19:0];
        apr_pkg::IDLE_SLOPE_OFS: st_nxt.idle_slope = reg_wdata[19:0];
        apr_pkg::NS_OFFSET_OFS: begin
          st_nxt.ns_ofs = reg_wdata[29:0];
          st_nxt.load   = 1'b1;
          st_nxt.ns     = reg_wdata[29:0];
          st_nxt.sec    = {st_r.sec_hi_ofs, st_r.sec_lo_ofs};
          st_nxt.frac   = 20'h00000;
        end
        apr_pkg::SEC_LO_OFS: st_nxt.sec_lo_ofs = reg_wdata;
        apr_pkg::SEC_HI_OFS: st_nxt.sec_hi_ofs = reg_wdata[15:0];
        apr_pkg::INCR_OFS:   st_nxt.incr = reg_wdata[25:0];
        apr_pkg::RTC_IRQ_CLR_OFS: st_nxt.irq_clr = 1'b1;
        apr_pkg::PHASE_ADJ_OFS:   st_nxt.phase = reg_wdata[29:0];
        default: ;
      endcase
    end

    // --------------------------------------------------------------------
    // Register reads
    // --------------------------------------------------------------------
    if (AVB_PRESENT && reg_rd) begin
      unique case (reg_addr)
        apr_pkg::RX_BUF_CTRL_OFS:
          st_nxt.rdata = {20'h00000, st_r.bin, 8'h00};
        apr_pkg::SEND_SLOPE_OFS: st_nxt.rdata = {12'h000, st_r.send_slope};
        apr_pkg::IDLE_SLOPE_OFS: st_nxt.rdata = {12'h000, st_r.idle_slope};
        apr_pkg::NS_OFFSET_OFS:  st_nxt.rdata = {2'b00, st_r.ns_ofs};
        apr_pkg::SEC_LO_OFS:     st_nxt.rdata = st_r.sec_lo_ofs;
        apr_pkg::SEC_HI_OFS:     st_nxt.rdata = {16'h0000, st_r.sec_hi_ofs};
        apr_pkg::INCR_OFS:       st_nxt.rdata = {6'h00, st_r.incr};
        apr_pkg::NOW_NS_OFS: begin
          // Reading nanoseconds freezes the seconds for the follow-up reads.
          st_nxt.rdata    = {2'b00, st_r.ns};
          st_nxt.snap_sec = st_r.sec;
        end
        apr_pkg::NOW_SEC_LO_OFS: st_nxt.rdata = st_r.snap_sec[31:0];
        apr_pkg::NOW_SEC_HI_OFS:
          st_nxt.rdata = {16'h0000, st_r.snap_sec[47:32]};
        apr_pkg::PHASE_ADJ_OFS:  st_nxt.rdata = {2'b00, st_r.phase};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r            <= '0;
      st_r.send_slope <= apr_pkg::SEND_SLOPE_RST;
      st_r.idle_slope <= apr_pkg::IDLE_SLOPE_RST;
      st_r.bin        <= apr_pkg::RX_BIN_RST;
      st_r.ns_ofs     <= apr_pkg::NS_OFFSET_RST;
      st_r.sec_lo_ofs <= apr_pkg::SEC_LO_RST;
      st_r.sec_hi_ofs <= apr_pkg::SEC_HI_RST;
      st_r.incr       <= apr_pkg::INCR_RST;
      st_r.phase      <= apr_pkg::PHASE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata      = st_r.rdata;
  assign rx_flush       = st_r.flush;
  assign rx_wr_ptr_load = st_r.wr_ptr_load;
  assign rx_irq         = st_r.irq;
  assign send_slope     = st_r.send_slope;
  assign idle_slope     = st_r.idle_slope;
  assign rtc_load       = st_r.load;
  assign rtc_ns         = st_r.ns;
  assign rtc_sec        = st_r.sec;
  assign phase_adjust   = st_r.phase;
  assign rtc_irq_clear  = st_r.irq_clr;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Checks of the register map other than a_slope_reset, a_absent_quiet and a_rdata_idle hold only in a build with the option in.

  // ----------------------------------------------------------------------
  // RX buffer control checks
  // ----------------------------------------------------------------------
  a_flush_pulse: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_wr && reg_addr == apr_pkg::RX_BUF_CTRL_OFS && reg_wdata[0]
    |=> rx_flush && rx_wr_ptr_load == $past(rx_rd_ptr))
    else $error("flush did not follow a flush write");

  a_flush_quiet: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    !(reg_wr && reg_addr == apr_pkg::RX_BUF_CTRL_OFS && reg_wdata[0])
    |=> !rx_flush)
    else $error("flush without a flush write");

  a_flush_reads_zero: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_rd && reg_addr == apr_pkg::RX_BUF_CTRL_OFS
    |=> reg_rdata[7:0] == 8'h00)
    else $error("flush bit read nonzero");

  a_bin_read: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_rd && reg_addr == apr_pkg::RX_BUF_CTRL_OFS
    |=> reg_rdata[11:8] == $past(st_r.bin)
        && reg_rdata[31:12] == 20'h00000)
    else $error("bin index read wrong");

  a_irq_clear_access: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    ctrl_hit && !rx_ts_stored |=> !rx_irq)
    else $error("rx interrupt not cleared by access");

  a_irq_on_frame: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    rx_ts_stored |=> rx_irq && st_r.bin == $past(rx_ts_bin))
    else $error("rx interrupt or bin missed a frame");

  a_irq_hold: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    !rx_ts_stored && !ctrl_hit |=> rx_irq == $past(rx_irq))
    else $error("rx interrupt moved without cause");

  a_bin_hold: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    !rx_ts_stored |=> st_r.bin == $past(st_r.bin))
    else $error("bin index moved without a stored frame");

  // ----------------------------------------------------------------------
  // Shaper slope checks
  // ----------------------------------------------------------------------
  a_slope_reset: assert property (
    @(posedge mclk)
    rst |=> send_slope == apr_pkg::SEND_SLOPE_RST
            && idle_slope == apr_pkg::IDLE_SLOPE_RST)
    else $error("slope reset values wrong");

  a_send_write: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_wr && reg_addr == apr_pkg::SEND_SLOPE_OFS
    |=> send_slope == $past(reg_wdata[19:0]))
    else $error("send slope write lost");

  a_idle_write: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_wr && reg_addr == apr_pkg::IDLE_SLOPE_OFS
    |=> idle_slope == $past(reg_wdata[19:0]))
    else $error("idle slope write lost");

  a_absent_quiet: assert property (
    @(posedge mclk) disable iff (rst)
    !AVB_PRESENT && reg_rd |=> reg_rdata == 32'h00000000)
    else $error("register read in a build without the option");

  // ----------------------------------------------------------------------
  // RTC checks
  // ----------------------------------------------------------------------
  a_load_linked: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_wr && reg_addr == apr_pkg::NS_OFFSET_OFS
    |=> rtc_load && rtc_ns == $past(reg_wdata[29:0])
        && rtc_sec == $past({st_r.sec_hi_ofs, st_r.sec_lo_ofs}))
    else $error("offset load did not step the counter");

  a_sec_no_load: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_wr && reg_addr != apr_pkg::NS_OFFSET_OFS |=> !rtc_load)
    else $error("load without nanosecond offset write");

  a_ns_kept: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_wr && reg_addr == apr_pkg::NS_OFFSET_OFS
    |=> st_r.ns_ofs == $past(reg_wdata[29:0]))
    else $error("ns offset write lost");

  a_ns_reserved: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_rd && reg_addr == apr_pkg::NS_OFFSET_OFS
    |=> reg_rdata[31:30] == 2'b00)
    else $error("reserved ns bits nonzero");

  a_lo_read: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_rd && reg_addr == apr_pkg::SEC_LO_OFS
    |=> reg_rdata == $past(st_r.sec_lo_ofs))
    else $error("seconds low offset read wrong");

  a_hi_write: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_wr && reg_addr == apr_pkg::SEC_HI_OFS
    |=> st_r.sec_hi_ofs == $past(reg_wdata[15:0]))
    else $error("seconds high offset write lost");

  a_hi_reserved: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_rd && reg_addr == apr_pkg::SEC_HI_OFS
    |=> reg_rdata[31:16] == 16'h0000)
    else $error("reserved seconds bits nonzero");

  a_rtc_advance: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    st_r.frac == 20'h00000 && st_r.incr == 26'h0100000
    && st_r.ns < NS_LIMIT - 30'h00000002
    && !(reg_wr && reg_addr == apr_pkg::NS_OFFSET_OFS)
    |=> rtc_ns == $past(rtc_ns) + 30'h00000001)
    else $error("counter did not advance by one nanosecond");

  a_clr_pulse: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    1'b1 |=> rtc_irq_clear
             == $past(reg_wr && reg_addr == apr_pkg::RTC_IRQ_CLR_OFS))
    else $error("timer interrupt clear pulse wrong");

  a_snapshot: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_rd && reg_addr == apr_pkg::NOW_NS_OFS
    |=> st_r.snap_sec == $past(rtc_sec))
    else $error("seconds not sampled by nanosecond read");

  a_unmapped_zero: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_rd && reg_addr == 17'h12804 |=> reg_rdata == 32'h00000000)
    else $error("reserved address read nonzero");

  a_reserved_write: assert property (
    @(posedge mclk) disable iff (rst || !AVB_PRESENT)
    reg_wr && reg_addr == 17'h12804
    |=> $stable(st_r.ns_ofs) && $stable(st_r.sec_lo_ofs)
        && $stable(st_r.sec_hi_ofs))
    else $error("reserved address write changed an offset");

  a_rdata_idle: assert property (
    @(posedge mclk) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside a read");

  c_flush: cover property (@(posedge mclk) disable iff (rst) rx_flush);

  c_load: cover property (@(posedge mclk) disable iff (rst) rtc_load);

  c_irq_race: cover property (@(posedge mclk) disable iff (rst)
    ctrl_hit && rx_ts_stored);

  c_sec_roll: cover property (@(posedge mclk) disable iff (rst)
    rtc_sec != $past(rtc_sec) && !rtc_load);

  c_snapshot: cover property (@(posedge mclk) disable iff (rst)
    reg_rd && reg_addr == apr_pkg::NOW_SEC_LO_OFS);

endmodule : apr_regs

// ---- verification/tb.sv ----
// Self-checking testbench for the AVB register bank.
`timescale 1ns/1ps
module tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [16:0] reg_addr = 17'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        rx_ts_stored = 1'b0;
  logic [3:0]  rx_ts_bin = 4'h0;
  logic [3:0]  rx_rd_ptr = 4'h0;
  logic        rx_flush;
  logic [3:0]  rx_wr_ptr_load;
  logic        rx_irq;
  logic [19:0] send_slope;
  logic [19:0] idle_slope;
  logic        rtc_load;
  logic [29:0] rtc_ns;
  logic [47:0] rtc_sec;
  logic [29:0] phase_adjust;
  logic        rtc_irq_clear;
  logic [31:0] rd_val;
  logic [31:0] off_rdata;
  logic [29:0] ns_seen;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #12.5 mclk = ~mclk;

  apr_regs i_dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_ts_stored, .rx_ts_bin, .rx_rd_ptr, .rx_flush,
    .rx_wr_ptr_load, .rx_irq, .send_slope, .idle_slope, .rtc_load,
    .rtc_ns, .rtc_sec, .phase_adjust, .rtc_irq_clear);

  // A build without the option must answer every read with zero.
  apr_regs #(.AVB_PRESENT(1'b0)) i_dut_off (.mclk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(off_rdata), .rx_ts_stored,
    .rx_ts_bin, .rx_rd_ptr, .rx_flush(), .rx_wr_ptr_load(), .rx_irq(),
    .send_slope(), .idle_slope(), .rtc_load(), .rtc_ns(), .rtc_sec(),
    .phase_adjust(), .rtc_irq_clear());

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobes drop at the taking edge; results are sampled just after it.
  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rdchk(input logic [16:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    chk(rd_val, exp);
  endtask : rdchk

  task automatic frame(input logic [3:0] b);
    @(posedge mclk);
    rx_ts_stored <= 1'b1;
    rx_ts_bin <= b;
    @(posedge mclk);
    rx_ts_stored <= 1'b0;
    #1;
  endtask : frame

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rdchk(apr_pkg::SEND_SLOPE_OFS, 32'h800);
    chk(off_rdata, 32'h0);
    rdchk(apr_pkg::IDLE_SLOPE_OFS, 32'h1800);
    rdchk(apr_pkg::RX_BUF_CTRL_OFS, 32'h0);
    rdchk(apr_pkg::NS_OFFSET_OFS, 32'h0);
    rdchk(apr_pkg::SEC_LO_OFS, 32'h0);
    rdchk(apr_pkg::SEC_HI_OFS, 32'h0);
    wr(apr_pkg::SEND_SLOPE_OFS, 32'hffffffff);
    wr(apr_pkg::IDLE_SLOPE_OFS, 32'hfff12345);
    rdchk(apr_pkg::SEND_SLOPE_OFS, 32'h000fffff);
    rdchk(apr_pkg::IDLE_SLOPE_OFS, 32'h00012345);
    chk(send_slope, 20'hfffff);
    chk(idle_slope, 20'h12345);
    wr(17'h12804, 32'hffffffff);
    rdchk(17'h12804, 32'h0);
    rdchk(17'h12828, 32'h0);
    rdchk(17'h13ffc, 32'h0);
    frame(4'ha);
    chk(rx_irq, 1'b1);
    rdchk(apr_pkg::RX_BUF_CTRL_OFS, 32'ha00);
    chk(rx_irq, 1'b0);
    frame(4'h3);
    chk(rx_irq, 1'b1);
    rx_rd_ptr <= 4'h5;
    wr(apr_pkg::RX_BUF_CTRL_OFS, 32'hffffffff);
    chk(rx_flush, 1'b1);
    chk(rx_wr_ptr_load, 4'h5);
    chk(rx_irq, 1'b0);
    rdchk(apr_pkg::RX_BUF_CTRL_OFS, 32'h300);
    wr(apr_pkg::RX_BUF_CTRL_OFS, 32'h0);
    chk(rx_flush, 1'b0);
    wr(apr_pkg::SEC_LO_OFS, 32'h89abcdef);
    chk(rtc_load, 1'b0);
    wr(apr_pkg::SEC_HI_OFS, 32'hffff0042);
    chk(rtc_load, 1'b0);
    chk(rtc_sec, 48'h0);
    rdchk(apr_pkg::SEC_HI_OFS, 32'h42);
    rdchk(apr_pkg::SEC_LO_OFS, 32'h89abcdef);
    wr(apr_pkg::NS_OFFSET_OFS, 32'hd2345678);
    chk(rtc_load, 1'b1);
    rdchk(apr_pkg::NS_OFFSET_OFS, 32'h12345678);
    chk(rtc_ns, 30'h12345678);
    chk(rtc_sec, 48'h004289abcdef);
    wr(apr_pkg::INCR_OFS, 32'hfc100000);
    rdchk(apr_pkg::INCR_OFS, 32'h00100000);
    ns_seen = rtc_ns;
    @(posedge mclk);
    #1;
    chk(rtc_ns, ns_seen + 30'h1);
    rdchk(apr_pkg::NOW_NS_OFS, {2'b00, ns_seen + 30'h2});
    rdchk(apr_pkg::NOW_SEC_LO_OFS, 32'h89abcdef);
    rdchk(apr_pkg::NOW_SEC_HI_OFS, 32'h42);
    wr(apr_pkg::RTC_IRQ_CLR_OFS, 32'h1);
    chk(rtc_irq_clear, 1'b1);
    wr(apr_pkg::PHASE_ADJ_OFS, 32'hffffffff);
    rdchk(apr_pkg::PHASE_ADJ_OFS, 32'h3fffffff);
    chk(phase_adjust, 30'h3fffffff);
    report_and_stop();
  end
endmodule : tb
